// ### rtl/srapc_host.sv
// Purpose: Host controller driving a parallel NOR flash secured region
// Assumes: Flash pins asynchronous to CLK; ready_busy_n synchronised
// Notes:   One command at a time; REQ taken only while READY is high
`timescale 1ns/1ps
module srapc_host
	import srapc_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              SRST,
	input  wire logic              CE,
	input  wire logic              REQ,
	input  wire logic [2:0]        OP,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	output logic                   READY,
	output logic                   RVALID,
	output logic [DATA_W-1:0]      RDATA,
	output logic                   REFUSED,
	output logic                   SECURED,
	output logic                   FLASH_CE_N,
	output logic                   FLASH_OE_N,
	output logic                   FLASH_WE_N,
	output logic                   FLASH_RESET_N,
	output logic                   FLASH_BOOST,
	output logic [ADDR_W-1:0]      FLASH_A,
	output logic [DATA_W-1:0]      FLASH_DQ_O,
	output logic                   FLASH_DQ_OE,
	input  wire logic [DATA_W-1:0] FLASH_DQ_I,
	input  wire logic              FLASH_READY_BUSY_N
);
	// ==========================================================
	// Pin synchronisers
	logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
	logic              rb_s1_q, rb_s2_q;
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
		end
		else if (CE)
		begin
			dq_s1_q <= FLASH_DQ_I;
			dq_s2_q <= dq_s1_q;
			rb_s1_q <= FLASH_READY_BUSY_N;
			rb_s2_q <= rb_s1_q;
		end
	end

	// ==========================================================
	// Sequencer
	srapc_state_t      st_q, st_d;
	logic [1:0]        step_q, step_d, last_q, last_d;
	logic [3:0]        cnt_q, cnt_d;
	srapc_op_t         op_q, op_d;
	logic [ADDR_W-1:0] a_q, a_d;
	logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
	logic              sec_q, sec_d, rv_q, rv_d, ref_q, ref_d;
	logic              ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
	logic              rst_n_q, rst_n_d, dqoe_q, dqoe_d, rdy_q, rdy_d;
	logic [ADDR_W-1:0] cyc_a;
	logic [DATA_W-1:0] cyc_d;
	logic              in_region;

	// Address of region access inside the 128-word region (00h to 7Fh)
	assign in_region = (ADDR[ADDR_W-1:7] == '0);

	always_comb
	begin
		// Step table for multi-write sequences
		cyc_a = UNLOCK1_ADDR;
		cyc_d = UNLOCK1_DATA;
		case (step_q)
			2'd0:
			begin
				cyc_a = UNLOCK1_ADDR;
				cyc_d = UNLOCK1_DATA;
			end
			2'd1:
			begin
				cyc_a = UNLOCK2_ADDR;
				cyc_d = UNLOCK2_DATA;
			end
			2'd2:
			begin
				cyc_a = UNLOCK1_ADDR;
				cyc_d = (op_q == SRAPC_OP_ENTER) ? ENTER_DATA :
					(op_q == SRAPC_OP_PROG) ? PROG_DATA : EXIT3_DATA;
			end
			default:
			begin
				cyc_a = (op_q == SRAPC_OP_EXIT) ? EXIT4_ADDR : a_q;
				cyc_d = (op_q == SRAPC_OP_EXIT) ? EXIT4_DATA : wd_q;
			end
		endcase
		if (op_q == SRAPC_OP_WRITE)
		begin
			cyc_a = a_q;
			cyc_d = wd_q;
		end
	end

	always_comb
	begin
		st_d    = st_q;
		step_d  = step_q;
		last_d  = last_q;
		cnt_d   = cnt_q;
		op_d    = op_q;
		a_d     = a_q;
		wd_d    = wd_q;
		rd_d    = rd_q;
		sec_d   = sec_q;
		rv_d    = 1'b0;
		ref_d   = 1'b0;
		ce_n_d  = ce_n_q;
		oe_n_d  = oe_n_q;
		we_n_d  = we_n_q;
		rst_n_d = rst_n_q;
		dqoe_d  = dqoe_q;
		rdy_d   = rdy_q;
		case (st_q)
			SRAPC_IDLE:
			begin
				// Deselect and float between accesses; address held so the part may sleep
				ce_n_d = 1'b1;
				oe_n_d = 1'b1;
				if (REQ && rdy_q)
				begin
					op_d  = srapc_op_t'(OP);
					a_d   = ADDR;
					wd_d  = WDATA;
					step_d = 2'd0;
					if (OP == SRAPC_OP_RESET)
					begin
						rst_n_d = 1'b0;
						cnt_d   = RST_CNT;
						rdy_d   = 1'b0;
						st_d    = SRAPC_RST;
					end
					else if (sec_q && !rb_s2_q && (OP == SRAPC_OP_PROG ||
						(OP == SRAPC_OP_READ && in_region)))
						ref_d = 1'b1;
					else if ((OP == SRAPC_OP_PROG && (!sec_q || !in_region)) ||
						(OP == SRAPC_OP_ENTER && sec_q) || (OP == SRAPC_OP_EXIT && !sec_q))
						ref_d = 1'b1;
					else if (OP == SRAPC_OP_READ)
					begin
						ce_n_d = 1'b0;
						oe_n_d = 1'b0;
						cnt_d  = ACC_CNT;
						rdy_d  = 1'b0;
						st_d   = SRAPC_RD;
					end
					else
					begin
						// Boost pin never raised in secured mode
						last_d = (OP == SRAPC_OP_WRITE) ? 2'd0 :
							(OP == SRAPC_OP_ENTER) ? 2'd2 : 2'd3;
						rdy_d  = 1'b0;
						st_d   = SRAPC_WSET;
					end
				end
			end
			SRAPC_WSET:
			begin
				ce_n_d = 1'b0;
				we_n_d = 1'b0;
				dqoe_d = 1'b1;
				cnt_d  = WE_CNT;
				st_d   = SRAPC_WHOLD;
			end
			SRAPC_WHOLD:
			begin
				if (cnt_q != 4'h0)
					cnt_d = cnt_q - 4'h1;
				else
				begin
					// Chip stays selected so the write edge is set by WE alone
					we_n_d = 1'b1;
					if (step_q == last_q)
					begin
						st_d = SRAPC_DONE;
						if (op_q == SRAPC_OP_ENTER)
							sec_d = 1'b1;
						if (op_q == SRAPC_OP_EXIT)
							sec_d = 1'b0;
					end
					else
					begin
						step_d = step_q + 2'd1;
						st_d   = SRAPC_WSET;
					end
				end
			end
			SRAPC_RD:
			begin
				if (cnt_q != 4'h0)
					cnt_d = cnt_q - 4'h1;
				else
				begin
					// Lock bit at 03h, serial words are plain reads
					rd_d   = dq_s2_q;
					rv_d   = 1'b1;
					ce_n_d = 1'b1;
					oe_n_d = 1'b1;
					st_d   = SRAPC_DONE;
				end
			end
			SRAPC_RST:
			begin
				if (cnt_q != 4'h0)
					cnt_d = cnt_q - 4'h1;
				else
				begin
					rst_n_d = 1'b1;
					sec_d   = 1'b0;
					st_d    = SRAPC_DONE;
				end
			end
			SRAPC_DONE:
			begin
				// Deselect even while a program still runs in the part
				ce_n_d = 1'b1;
				dqoe_d = 1'b0;
				rdy_d  = 1'b1;
				st_d   = SRAPC_IDLE;
			end
			default:
				st_d = SRAPC_IDLE;
		endcase
	end

	// Address and data pins follow the current sequence step
	logic [ADDR_W-1:0] fa_q, fa_d;
	logic [DATA_W-1:0] fd_q, fd_d;
	always_comb
	begin
		fa_d = fa_q;
		fd_d = fd_q;
		if (st_q == SRAPC_IDLE && REQ && rdy_q && OP == SRAPC_OP_READ)
			fa_d = ADDR;
		else if (st_q == SRAPC_WSET || (st_q == SRAPC_IDLE && REQ && rdy_q && OP != SRAPC_OP_READ))
		begin
			fa_d = (st_q == SRAPC_WSET) ? cyc_a : fa_q;
			fd_d = (st_q == SRAPC_WSET) ? cyc_d : fd_q;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			st_q    <= SRAPC_IDLE;
			step_q  <= 2'd0;
			last_q  <= 2'd0;
			cnt_q   <= 4'h0;
			op_q    <= SRAPC_OP_READ;
			a_q     <= 24'h000000;
			wd_q    <= 16'h0000;
			rd_q    <= 16'h0000;
			sec_q   <= 1'b0;
			rv_q    <= 1'b0;
			ref_q   <= 1'b0;
			ce_n_q  <= 1'b1;
			oe_n_q  <= 1'b1;
			we_n_q  <= 1'b1;
			rst_n_q <= 1'b1;
			dqoe_q  <= 1'b0;
			rdy_q   <= 1'b1;
			fa_q    <= 24'h000000;
			fd_q    <= 16'h0000;
		end
		else if (CE)
		begin
			st_q    <= st_d;
			step_q  <= step_d;
			last_q  <= last_d;
			cnt_q   <= cnt_d;
			op_q    <= op_d;
			a_q     <= a_d;
			wd_q    <= wd_d;
			rd_q    <= rd_d;
			sec_q   <= sec_d;
			rv_q    <= rv_d;
			ref_q   <= ref_d;
			ce_n_q  <= ce_n_d;
			oe_n_q  <= oe_n_d;
			we_n_q  <= we_n_d;
			rst_n_q <= rst_n_d;
			dqoe_q  <= dqoe_d;
			rdy_q   <= rdy_d;
			fa_q    <= fa_d;
			fd_q    <= fd_d;
		end
	end

	assign READY         = rdy_q;
	assign RVALID        = rv_q;
	assign RDATA         = rd_q;
	assign REFUSED       = ref_q;
	assign SECURED       = sec_q;
	assign FLASH_CE_N    = ce_n_q;
	assign FLASH_OE_N    = oe_n_q;
	assign FLASH_WE_N    = we_n_q;
	assign FLASH_RESET_N = rst_n_q;
	assign FLASH_BOOST   = 1'b0 & ~sec_q;
	assign FLASH_A       = fa_q;
	assign FLASH_DQ_O    = fd_q;
	assign FLASH_DQ_OE   = dqoe_q;

	// ==========================================================
	// Checks
	property p_oe_float;
		@(posedge CLK) disable iff (SRST) !oe_n_q |-> !dqoe_q;
	endproperty
	a_oe_float: assert property (p_oe_float) else $error("Bus driven while reading");

	property p_rst_width;
		@(posedge CLK) disable iff (SRST || !CE) $fell(rst_n_q) |-> !rst_n_q [*3];
	endproperty
	a_rst_width: assert property (p_rst_width) else $error("Reset pulse too short");

	property p_rst_clears_sec;
		@(posedge CLK) disable iff (SRST) $rose(rst_n_q) |-> !sec_q;
	endproperty
	a_rst_clears_sec: assert property (p_rst_clears_sec) else $error("Secured after reset");

	property p_enter_sets;
		@(posedge CLK) disable iff (SRST) $rose(sec_q) |-> op_q == SRAPC_OP_ENTER && step_q == 2'd2;
	endproperty
	a_enter_sets: assert property (p_enter_sets) else $error("Secured without entry");

	property p_exit_clears;
		@(posedge CLK) disable iff (SRST) $fell(sec_q) |-> (op_q == SRAPC_OP_EXIT && step_q == 2'd3) || !rst_n_q
			|| op_q == SRAPC_OP_RESET;
	endproperty
	a_exit_clears: assert property (p_exit_clears) else $error("Secured dropped early");

	property p_boost_off;
		@(posedge CLK) disable iff (SRST) sec_q |-> !FLASH_BOOST;
	endproperty
	a_boost_off: assert property (p_boost_off) else $error("Boost in secured mode");

	property p_idle_deselect;
		@(posedge CLK) disable iff (SRST || !CE) st_q == SRAPC_IDLE && $past(st_q) == SRAPC_IDLE |-> ce_n_q;
	endproperty
	a_idle_deselect: assert property (p_idle_deselect) else $error("Chip selected in idle");

	property p_read_time;
		@(posedge CLK) disable iff (SRST || !CE) $fell(oe_n_q) |-> ##[1:12] rv_q;
	endproperty
	a_read_time: assert property (p_read_time) else $error("Read never completed");
endmodule // srapc_host

// ### include/srapc_pkg.sv
// Purpose: Constants for the secured-region host controller
// Assumes: 16-bit word bus, 10 MHz CLK
// Notes:   Word addresses only
package srapc_pkg;
	localparam int          CLK_MHZ            = 10;
	localparam int          ADDR_W             = 24;
	localparam int          DATA_W             = 16;
	// Bus cycle timing
	localparam int          ACC_NS             = 110;
	localparam int          ACC_CYC            = (ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int          WE_NS              = 35;
	localparam int          WE_CYC             = (WE_NS * CLK_MHZ + 999) / 1000;
	localparam int          RST_PULSE_NS       = 500;
	localparam int          RST_CYC            = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  ACC_CNT            = 4'(ACC_CYC);
	localparam logic [3:0]  WE_CNT             = 4'(WE_CYC);
	localparam logic [3:0]  RST_CNT            = 4'(RST_CYC);
	// Command addresses and data
	localparam logic [23:0] UNLOCK1_ADDR       = 24'h000555;
	localparam logic [23:0] UNLOCK2_ADDR       = 24'h0002AA;
	localparam logic [23:0] EXIT4_ADDR         = 24'h000000;
	localparam logic [15:0] UNLOCK1_DATA       = 16'h00AA;
	localparam logic [15:0] UNLOCK2_DATA       = 16'h0055;
	localparam logic [15:0] ENTER_DATA         = 16'h0088;
	localparam logic [15:0] PROG_DATA          = 16'h00A0;
	localparam logic [15:0] EXIT3_DATA         = 16'h0090;
	localparam logic [15:0] EXIT4_DATA         = 16'h0000;
	localparam logic [23:0] ID_LOCK_ADDR       = 24'h000003;
	localparam int          LOCK_BIT           = 7;
	localparam logic [6:0]  REGION_LAST        = 7'h7F;
	localparam logic [2:0]  SERIAL_LAST        = 3'h7;
	// Operations and sequencer states
	typedef enum logic [2:0]
	{
		SRAPC_OP_READ  = 3'b000,
		SRAPC_OP_WRITE = 3'b001,
		SRAPC_OP_ENTER = 3'b010,
		SRAPC_OP_PROG  = 3'b011,
		SRAPC_OP_EXIT  = 3'b100,
		SRAPC_OP_RESET = 3'b101
	} srapc_op_t;
	typedef enum logic [2:0]
	{
		SRAPC_IDLE  = 3'b000,
		SRAPC_WSET  = 3'b001,
		SRAPC_WHOLD = 3'b010,
		SRAPC_RD    = 3'b011,
		SRAPC_RST   = 3'b100,
		SRAPC_DONE  = 3'b101
	} srapc_state_t;
endpackage

// ### sim/srapc_flash_model.sv
// Purpose: Behavioural parallel NOR flash for the host bench
// Assumes: Word addressing, zero-delay pins
// Notes:   Released data bus shows the inverse of the last word
`timescale 1ns/1ps
module srapc_flash_model #(
	parameter int BUSY_NS = 3000,
	parameter int SECT_W  = 16,
	parameter bit LOCKED  = 1'h0
) (
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        reset_n,
	input  wire logic [23:0] a,
	input  wire logic [15:0] dq_i,
	output logic      [15:0] dq_o,
	output logic             rb_n
);
	// ==========
	// Command decode
	logic [15:0] region [128];
	logic [23:0] al;
	logic [15:0] dl, rd, hold;
	logic [1:0]  step;
	logic        sec, prog, quit, drv;
	initial
	begin
		foreach (region[i]) region[i] = 16'hFFFF;
		rb_n = 1'h1;
		hold = 16'h0000;
		step = 2'h0;
		sec = 1'h0;
		prog = 1'h0;
		quit = 1'h0;
	end
	// Address and data taken on the rising strobe; host holds both over the pulse
	always @(posedge we_n or negedge reset_n)
	begin
		al = a;
		dl = dq_i;
		if (!reset_n)
		begin
			step = 2'h0;
			sec = 1'h0;
			prog = 1'h0;
			quit = 1'h0;
		end
		else if (!ce_n)
		begin
			if (prog)
			begin
				if (!LOCKED && al < 24'h000080)
					region[al[6:0]] = dl;
				prog = 1'h0;
				rb_n = 1'h0;
				rb_n <= #(BUSY_NS) 1'h1;
			end
			else if (quit)
			begin
				if (al == 24'h000000 && dl == 16'h0000)
					sec = 1'h0;
				quit = 1'h0;
			end
			else if (step == 2'h2)
			begin
				step = 2'h0;
				if (al == 24'h000555 && dl == 16'h0088)
					sec = 1'h1;
				prog = sec && al == 24'h000555 && dl == 16'h00A0;
				quit = sec && al == 24'h000555 && dl == 16'h0090;
			end
			else if (al == (step[0] ? 24'h0002AA : 24'h000555) && dl == (step[0] ? 16'h0055 : 16'h00AA))
				step = step + 2'h1;
			else
				step = 2'h0;
		end
	end
	// ==========
	// Read path
	always_comb
	begin
		if (sec && (a >> SECT_W) == 24'h000000)
			rd = (!rb_n || a > 24'h00007F) ? ~a[15:0] : region[a[6:0]];
		else
			rd = a[15:0] ^ 16'h5A5A;
	end
	assign drv = !ce_n && !oe_n && reset_n;
	always @*
		if (drv)
			hold = rd;
	assign dq_o = drv ? rd : ~hold;
endmodule // srapc_flash_model

// ### sim/srapc_host_test.sv
// Purpose: Self-checking bench for the secured-region host
// Assumes: Flash model on the far side, CE held high
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ps
module srapc_host_test
	import srapc_pkg::*;
;
	logic              CLK, SRST, CE, REQ, READY, RVALID, REFUSED, SECURED;
	logic              FLASH_CE_N, FLASH_OE_N, FLASH_WE_N, FLASH_RESET_N, FLASH_BOOST, FLASH_DQ_OE, rb_n;
	logic [2:0]        OP;
	logic [23:0]       ADDR, FLASH_A;
	logic [15:0]       WDATA, RDATA, FLASH_DQ_O, dq_o, rdat;
	logic              rv, rf;
	int                rst_lo, we_lo, err_count, check_count;
	srapc_host DUT (.CLK(CLK), .SRST(SRST), .CE(CE), .REQ(REQ), .OP(OP), .ADDR(ADDR), .WDATA(WDATA),
		.READY(READY), .RVALID(RVALID), .RDATA(RDATA), .REFUSED(REFUSED), .SECURED(SECURED),
		.FLASH_CE_N(FLASH_CE_N), .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N),
		.FLASH_RESET_N(FLASH_RESET_N), .FLASH_BOOST(FLASH_BOOST), .FLASH_A(FLASH_A),
		.FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE(FLASH_DQ_OE), .FLASH_DQ_I(dq_o), .FLASH_READY_BUSY_N(rb_n));
	srapc_flash_model u_flash (.ce_n(FLASH_CE_N), .oe_n(FLASH_OE_N), .we_n(FLASH_WE_N),
		.reset_n(FLASH_RESET_N), .a(FLASH_A), .dq_i(FLASH_DQ_OE ? FLASH_DQ_O : dq_o), .dq_o(dq_o), .rb_n(rb_n));
	initial
	begin
		CLK = 1'h0;
		forever #50 CLK = ~CLK;
	end
	// ==========
	// Shared tasks
	function automatic logic [15:0] arr(input logic [23:0] ad);
		return ad[15:0] ^ 16'h5A5A;
	endfunction
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic do_op(input srapc_op_t o, input logic [23:0] ad, input logic [15:0] wd);
		@(negedge CLK);
		REQ = 1'h1;
		OP = o;
		ADDR = ad;
		WDATA = wd;
		@(negedge CLK);
		REQ = 1'h0;
		rv = 1'h0;
		rf = 1'h0;
		rst_lo = 0;
		we_lo = 0;
		for (int n = 0; n < 200; n++)
		begin
			if (RVALID === 1'h1)
				rdat = RDATA;
			rv |= RVALID === 1'h1;
			rf |= REFUSED === 1'h1;
			rst_lo += int'(FLASH_RESET_N === 1'h0);
			we_lo += int'(FLASH_WE_N === 1'h0);
			if (n > 2 && READY === 1'h1 && RVALID !== 1'h1)
				break;
			@(negedge CLK);
		end
		chk(READY, 1);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic t_reset();
		chk(READY, 1);
		chk(SECURED, 0);
		chk({FLASH_CE_N, FLASH_OE_N, FLASH_WE_N, FLASH_RESET_N, FLASH_DQ_OE}, 24'h1E);
	endtask
	task automatic t_normal();
		do_op(SRAPC_OP_READ, 24'h000010, 16'h0000);
		chk(rdat, arr(24'h000010));
		chk(FLASH_CE_N, 1);
		do_op(SRAPC_OP_EXIT, 24'h000000, 16'h0000);
		chk(rf, 1);
		do_op(SRAPC_OP_PROG, 24'h000005, 16'h1234);
		chk(rf, 1);
		do_op(SRAPC_OP_WRITE, 24'h000000, 16'h00F0);
		chk({rf, u_flash.sec}, 0);
		chk(we_lo, WE_CYC + 1);
		chk({FLASH_CE_N, FLASH_DQ_OE}, 24'h2);
	endtask
	task automatic t_secured();
		do_op(SRAPC_OP_ENTER, 24'h000000, 16'h0000);
		chk({SECURED, u_flash.sec, FLASH_BOOST}, 24'h6);
		chk(we_lo, 3 * (WE_CYC + 1));
		do_op(SRAPC_OP_ENTER, 24'h000000, 16'h0000);
		chk({rf, u_flash.sec}, 24'h3);
		do_op(SRAPC_OP_PROG, 24'h00007F, 16'hC35A);
		chk(rf, 0);
		chk(we_lo, 4 * (WE_CYC + 1));
		repeat (3) @(negedge CLK);
		do_op(SRAPC_OP_PROG, 24'h000010, 16'h2222);
		chk(rf, 1);
		do_op(SRAPC_OP_READ, 24'h00007F, 16'h0000);
		chk(rf, 1);
		for (int n = 0; n < 100 && rb_n !== 1'h1; n++)
			@(negedge CLK);
		repeat (3) @(negedge CLK);
		do_op(SRAPC_OP_READ, 24'h00007F, 16'h0000);
		chk(rdat, 16'hC35A);
		do_op(SRAPC_OP_PROG, 24'h000080, 16'h1111);
		chk(rf, 1);
		do_op(SRAPC_OP_READ, 24'h010000, 16'h0000);
		chk(rdat, arr(24'h010000));
	endtask
	task automatic t_exit();
		do_op(SRAPC_OP_EXIT, 24'h000000, 16'h0000);
		chk({SECURED, u_flash.sec}, 24'h0);
		chk(we_lo, 4 * (WE_CYC + 1));
		do_op(SRAPC_OP_READ, 24'h00007F, 16'h0000);
		chk(rdat, arr(24'h00007F));
	endtask
	task automatic t_hwreset();
		do_op(SRAPC_OP_ENTER, 24'h000000, 16'h0000);
		do_op(SRAPC_OP_RESET, 24'h000000, 16'h0000);
		chk(rst_lo >= RST_CYC, 1);
		chk({SECURED, u_flash.sec}, 24'h0);
		do_op(SRAPC_OP_READ, 24'h000005, 16'h0000);
		chk(rdat, arr(24'h000005));
		do_op(SRAPC_OP_ENTER, 24'h000000, 16'h0000);
		chk({SECURED, u_flash.sec}, 24'h3);
		do_op(SRAPC_OP_EXIT, 24'h000000, 16'h0000);
		chk({SECURED, u_flash.sec}, 24'h0);
	endtask
	initial
	begin
		{SRST, CE, REQ, OP, ADDR, WDATA} = {2'h3, 44'h0};
		err_count = 0;
		check_count = 0;
		repeat (4) @(posedge CLK);
		@(negedge CLK);
		SRST = 1'h0;
		t_reset();
		t_normal();
		t_secured();
		t_exit();
		t_hwreset();
		summarize();
	end
	// Far beyond the few hundred cycles the scenarios need
	initial
	begin
		#2000000;
		err_count++;
		summarize();
	end
endmodule // srapc_host_test
